// >>> hw/fpl_pkg.sv
package fpl_pkg;

  localparam logic [7:0] OPC_LOCK_WR   = 8'hA6;
  localparam logic [7:0] OPC_PASS_RD   = 8'hE7;
  localparam logic [7:0] OPC_PASS_PROG = 8'hE8;
  localparam logic [7:0] OPC_PASS_UNLK = 8'hE9;
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0] OPC_STAT_RD   = 8'h05;
  localparam logic [7:0] OPC_CLR_STAT  = 8'h30;
  localparam logic [7:0] OPC_SW_RESET  = 8'hF0;

  localparam int unsigned PW_BITS       = 64;
  localparam logic [6:0]  CNT_CMD       = 7'h08;
  localparam logic [6:0]  CNT_CMD_DATA  = 7'h48;
  localparam logic [6:0]  CNT_SAT       = 7'h49;
  localparam logic [63:0] PW_RST        = 64'hFFFFFFFFFFFFFFFF;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PSL_US        = 40;
  localparam int unsigned ESL_US        = 45;
  localparam int unsigned PSL_CYC       = (PSL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned ESL_CYC       = (ESL_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RPH_NS_DEF    = 10000;
  localparam int unsigned RPH_CYC_DEF   = (RPH_NS_DEF + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CYC_DEF  = 40;
  localparam int unsigned PROG_CYC_DEF  = 200;
  localparam int unsigned UNLK_CYC_DEF  = 100;

  typedef struct packed {
    logic       srwd;
    logic       perr;
    logic       eerr;
    logic [2:0] bp;
    logic       write_enable_latch;
    logic       write_in_progress;
  } fpl_status_t;

  localparam fpl_status_t STATUS_RST = 8'h00;

  typedef struct packed {
    logic top_bottom_protect;
    logic top_bottom_param;
    logic block_protect_volatility;
  } fpl_cfg_nv_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [6:0]  bits;
    logic        mbr_ok;
    logic [63:0] data;
  } fpl_frame_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BUSY  = 4'b0010,
    ST_FAIL  = 4'b0100,
    ST_RECOV = 4'b1000
  } fpl_state_t;

  typedef enum logic [2:0] {
    OP_LOCK = 3'b001,
    OP_PROG = 3'b010,
    OP_UNLK = 3'b100
  } fpl_op_t;

endpackage

// >>> hw/fpl_lock_ctrl.sv
`timescale 1ns/1ps
module fpl_lock_ctrl
  import fpl_pkg::*;
#(
  parameter int unsigned LOCK_CYC = LOCK_CYC_DEF,
  parameter int unsigned PROG_CYC = PROG_CYC_DEF,
  parameter int unsigned UNLK_CYC = UNLK_CYC_DEF,
  parameter int unsigned RPH_CYC  = RPH_CYC_DEF
) (
  // System
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Serial link
  input  wire logic        link_sck,
  input  wire logic        cs_n,
  input  wire logic        data_line_zero,
  input  wire logic        data_line_four,
  output logic             so,
  output logic             so_oe,
  // Protection configuration
  input  wire logic        pw_mode_n,
  input  fpl_cfg_nv_t      cfg_nv,
  input  wire logic        freeze_set,
  input  wire logic        bp_load,
  input  wire logic [2:0]  bp_load_val,
  // Array engine
  input  wire logic        array_busy,
  input  wire logic        pass_prog_fail,
  input  wire logic        program_suspend_req,
  input  wire logic        erase_suspend_req,
  input  wire logic        resume_req,
  input  wire logic        cont_read_enter,
  // Status
  output fpl_status_t      status,
  output logic             sector_lock,
  output logic             freeze,
  output logic             cont_read,
  output logic             program_suspended,
  output logic             erase_suspended
);

  function automatic logic [63:0] byte_rev(input logic [63:0] v);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = v[8*(7-i) +: 8];
    end
    return r;
  endfunction

  // Link domain: frame capture on rising sck
  fpl_frame_t  frame_ff;
  logic        in_frame_ff;
  logic        frame_tog_ff;
  logic [5:0]  out_cnt_ff;
  logic        link_rst_n;
  logic        pwm_meta_ff;
  logic        pwm_sync_ff;
  logic [7:0]  st_meta_ff;
  logic [7:0]  st_sync_ff;
  logic        so_ff;
  logic        so_oe_ff;

  // Core domain registers read across by the link side
  logic [63:0] pw_ff;
  fpl_status_t status_ff;

  // Frame-local state clears while chip select is high
  assign link_rst_n = nrst & ~cs_n;

  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_frame_ff <= 1'b0;
    end else begin
      in_frame_ff <= 1'b1;
    end
  end

  // Frame contents survive chip select high so the core can read them afterwards
  always_ff @(posedge link_sck or negedge nrst) begin
    if (!nrst) begin
      frame_ff     <= '0;
      frame_tog_ff <= 1'b0;
      out_cnt_ff   <= 6'h00;
    end else if (!in_frame_ff) begin
      frame_ff.bits   <= 7'h01;
      frame_ff.opcode <= {7'h00, data_line_zero};
      frame_ff.data   <= 64'h0;
      frame_ff.mbr_ok <= data_line_zero & data_line_four;
      frame_tog_ff    <= ~frame_tog_ff;
      out_cnt_ff      <= 6'h00;
    end else begin
      if (frame_ff.bits != CNT_SAT) begin
        frame_ff.bits <= frame_ff.bits + 7'h01;
      end
      if (frame_ff.bits < CNT_CMD) begin
        frame_ff.opcode <= {frame_ff.opcode[6:0], data_line_zero};
        frame_ff.mbr_ok <= frame_ff.mbr_ok & data_line_zero & data_line_four;
      end else begin
        frame_ff.data <= {frame_ff.data[62:0], data_line_zero};
        out_cnt_ff    <= out_cnt_ff + 6'h01;
      end
    end
  end

  // These only settle over the opcode clocks; fine since both change rarely
  always_ff @(posedge link_sck or negedge nrst) begin
    if (!nrst) begin
      pwm_meta_ff <= 1'b1;
      pwm_sync_ff <= 1'b1;
      st_meta_ff  <= 8'h00;
      st_sync_ff  <= 8'h00;
    end else begin
      pwm_meta_ff <= pw_mode_n;
      pwm_sync_ff <= pwm_meta_ff;
      st_meta_ff  <= status_ff;
      st_sync_ff  <= st_meta_ff;
    end
  end

  // Output shifts on falling sck; password is quasi-static during any read frame
  always_ff @(negedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_ff    <= 1'b0;
      so_oe_ff <= 1'b0;
    end else if (in_frame_ff && frame_ff.bits >= CNT_CMD) begin
      if (frame_ff.opcode == OPC_STAT_RD) begin
        so_ff    <= st_sync_ff[~out_cnt_ff[2:0]];
        so_oe_ff <= 1'b1;
      end else if (frame_ff.opcode == OPC_PASS_RD && pwm_sync_ff) begin
        so_ff    <= pw_ff[{out_cnt_ff[5:3], ~out_cnt_ff[2:0]}];
        so_oe_ff <= 1'b1;
      end else begin
        so_ff    <= 1'b0;
        so_oe_ff <= 1'b0;
      end
    end else begin
      so_ff    <= 1'b0;
      so_oe_ff <= 1'b0;
    end
  end

  // Core domain: chip select crossing and frame toggle
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic cs_prev_ff;
  logic tog_meta_ff;
  logic tog_sync_ff;
  logic seen_tog_ff;
  logic frame_end;
  logic fresh;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cs_meta_ff  <= 1'b1;
      cs_sync_ff  <= 1'b1;
      cs_prev_ff  <= 1'b1;
      tog_meta_ff <= 1'b0;
      tog_sync_ff <= 1'b0;
      seen_tog_ff <= 1'b0;
    end else begin
      cs_meta_ff  <= cs_n;
      cs_sync_ff  <= cs_meta_ff;
      cs_prev_ff  <= cs_sync_ff;
      tog_meta_ff <= frame_tog_ff;
      tog_sync_ff <= tog_meta_ff;
      if (frame_end) begin
        seen_tog_ff <= tog_sync_ff;
      end
    end
  end

  // Frame registers are stable once chip select is seen high: sck stands still
  assign frame_end = cs_sync_ff & ~cs_prev_ff;
  assign fresh     = tog_sync_ff != seen_tog_ff;

  fpl_state_t  state_ff;
  fpl_op_t     op_ff;
  logic [31:0] timer_ff;
  logic [63:0] cand_ff;
  logic        wip_ff;
  logic        wel_ff;
  logic        perr_ff;
  logic [2:0]  bp_ff;
  logic        freeze_ff;
  logic        lock_ff;
  logic        init_done_ff;
  logic        cont_ff;
  logic [1:0]  susp_ff;

  logic cmd_ok;
  logic c_write_enable_cmd;
  logic c_lock;
  logic c_prog;
  logic c_unlk;
  logic c_clear_status_cmd;
  logic c_rst;
  logic c_mbr;
  logic idle;
  logic start_lock;
  logic start_prog;
  logic start_unlk;
  logic do_rst;
  logic do_clear_status_cmd;
  logic done;
  logic fail_now;

  // Any other bit count matches nothing and falls through untouched
  always_comb begin
    cmd_ok = frame_end & fresh & ~cont_ff;
    c_write_enable_cmd = cmd_ok && frame_ff.opcode == OPC_WRITE_ENABLE_CMD && frame_ff.bits == CNT_CMD;
    c_lock = cmd_ok && frame_ff.opcode == OPC_LOCK_WR && frame_ff.bits == CNT_CMD;
    c_prog = cmd_ok && frame_ff.opcode == OPC_PASS_PROG &&
             frame_ff.bits == CNT_CMD_DATA;
    c_unlk = cmd_ok && frame_ff.opcode == OPC_PASS_UNLK &&
             frame_ff.bits == CNT_CMD_DATA;
    c_clear_status_cmd = cmd_ok && frame_ff.opcode == OPC_CLR_STAT && frame_ff.bits == CNT_CMD;
    c_rst  = cmd_ok && frame_ff.opcode == OPC_SW_RESET && frame_ff.bits == CNT_CMD;
    c_mbr  = frame_end && fresh && cont_ff && frame_ff.bits == CNT_CMD &&
             frame_ff.mbr_ok;
    idle       = state_ff == ST_IDLE;
    start_lock = idle & c_lock & wel_ff;
    start_prog = idle & c_prog & wel_ff & pw_mode_n;
    start_unlk = idle & c_unlk;
    do_clear_status_cmd    = c_clear_status_cmd & (idle | (state_ff == ST_FAIL));
    do_rst     = c_rst & (idle | (state_ff == ST_FAIL));
    done       = (state_ff == ST_BUSY) && timer_ff == 32'h1;
    fail_now   = done && (((op_ff == OP_PROG) && pass_prog_fail) ||
                          ((op_ff == OP_UNLK) && cand_ff != pw_ff));
  end

  // Sequencer for self-timed operations and reset recovery
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      op_ff    <= OP_LOCK;
      timer_ff <= 32'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start_lock) begin
            state_ff <= ST_BUSY;
            op_ff    <= OP_LOCK;
            timer_ff <= LOCK_CYC;
          end else if (start_prog) begin
            state_ff <= ST_BUSY;
            op_ff    <= OP_PROG;
            timer_ff <= PROG_CYC;
          end else if (start_unlk) begin
            state_ff <= ST_BUSY;
            op_ff    <= OP_UNLK;
            timer_ff <= UNLK_CYC;
          end else if (do_rst) begin
            state_ff <= ST_RECOV;
            timer_ff <= RPH_CYC;
          end
        end
        ST_BUSY: begin
          if (done) begin
            state_ff <= fail_now ? ST_FAIL : ST_IDLE;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
        ST_FAIL: begin
          if (do_clear_status_cmd) begin
            state_ff <= ST_IDLE;
          end else if (do_rst) begin
            state_ff <= ST_RECOV;
            timer_ff <= RPH_CYC;
          end
        end
        ST_RECOV: begin
          // Commands other than the mode-bit reset are ignored until the recovery count runs out
          if (timer_ff <= 32'h1) begin
            state_ff <= ST_IDLE;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
      endcase
    end
  end

  // Candidate is copied out before the next frame overwrites the shifter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cand_ff <= 64'h0;
    end else if (start_prog || start_unlk) begin
      cand_ff <= byte_rev(frame_ff.data);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pw_ff <= PW_RST;
    end else if (done && op_ff == OP_PROG && !pass_prog_fail) begin
      pw_ff <= cand_ff;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wip_ff <= 1'b0;
    end else if (start_lock || start_prog || start_unlk) begin
      wip_ff <= 1'b1;
    end else if (done && !fail_now) begin
      wip_ff <= 1'b0;
    end else if (do_clear_status_cmd || do_rst) begin
      wip_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wel_ff <= 1'b0;
    end else if (idle && c_write_enable_cmd) begin
      wel_ff <= 1'b1;
    end else if (done || do_rst) begin
      wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      perr_ff <= 1'b0;
    end else if (fail_now) begin
      perr_ff <= 1'b1;
    end else if (do_clear_status_cmd || do_rst) begin
      perr_ff <= 1'b0;
    end
  end

  // Nonvolatile configuration is only read here, so reset cannot alter it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bp_ff <= 3'h0;
    end else if (bp_load) begin
      bp_ff <= bp_load_val;
    end else if (do_rst && !cfg_nv.block_protect_volatility && !freeze_ff) begin
      bp_ff <= 3'h0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      freeze_ff <= 1'b0;
    end else if (freeze_set) begin
      freeze_ff <= 1'b1;
    end
  end

  // Power-on lock value depends on protection mode, caught after release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      init_done_ff <= 1'b0;
      lock_ff      <= 1'b0;
    end else begin
      init_done_ff <= 1'b1;
      if (!init_done_ff) begin
        lock_ff <= pw_mode_n;
      end else if (done && op_ff == OP_LOCK) begin
        lock_ff <= 1'b0;
      end else if (done && op_ff == OP_UNLK && !fail_now) begin
        lock_ff <= 1'b1;
      end
    end
  end

  // Inside continuous read only the mode-bit reset is recognised by the core; status and password reads still answer on the link side
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cont_ff <= 1'b0;
    end else if (cont_read_enter) begin
      cont_ff <= 1'b1;
    end else if (c_mbr) begin
      cont_ff <= 1'b0;
    end
  end

  // Suspend latency counters, one per suspend kind
  localparam int unsigned SUSP_CYC [2] = '{PSL_CYC, ESL_CYC};
  logic [1:0] susp_req;
  assign susp_req = {erase_suspend_req, program_suspend_req};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_susp
      logic [15:0] lat_ff;
      logic        run_ff;
      logic        hit_ff;
      // Status flop adds one cycle, so flag one cycle early to meet the bound
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          lat_ff <= 16'h0;
          run_ff <= 1'b0;
          hit_ff <= 1'b0;
        end else if (resume_req) begin
          lat_ff <= 16'h0;
          run_ff <= 1'b0;
          hit_ff <= 1'b0;
        end else if (susp_req[gi] && array_busy && !hit_ff && !run_ff) begin
          lat_ff <= 16'h1;
          run_ff <= 1'b1;
        end else if (run_ff) begin
          if (lat_ff >= 16'(SUSP_CYC[gi] - 1)) begin
            run_ff <= 1'b0;
            hit_ff <= 1'b1;
          end else begin
            lat_ff <= lat_ff + 16'h1;
          end
        end
      end
      assign susp_ff[gi] = hit_ff;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff.srwd <= 1'b0;
      status_ff.eerr <= 1'b0;
      status_ff.perr <= perr_ff;
      status_ff.bp   <= bp_ff;
      status_ff.write_enable_latch  <= wel_ff;
      status_ff.write_in_progress  <= wip_ff | (array_busy & ~(|susp_ff));
    end
  end

  assign so                = so_ff;
  assign so_oe             = so_oe_ff;
  assign status            = status_ff;
  assign sector_lock       = lock_ff;
  assign freeze            = freeze_ff;
  assign cont_read         = cont_ff;
  assign program_suspended = susp_ff[0];
  assign erase_suspended   = susp_ff[1];

endmodule

// >>> sim/fpl_host_model.sv
`timescale 1ns/1ps
module fpl_host_model (
  // Serial link toward the device
  output logic      link_sck,
  output logic      cs_n,
  output logic      data_line_zero,
  output logic      data_line_four,
  // Serial answer
  input  wire logic so,
  input  wire logic so_oe
);
  logic io4_on = 1'h1;

  initial begin
    link_sck = 1'h0;
    cs_n = 1'h1;
    data_line_zero = 1'h0;
  end
  // Only the mode-bit reset needs this line; elsewhere it just follows the input line
  assign data_line_four = io4_on & data_line_zero;

  task automatic put(input logic b, output logic s, output logic e);
    data_line_zero = b;
    #62.5 link_sck = 1'h1;
    s = so;
    e = so_oe;
    #62.5 link_sck = 1'h0;
  endtask

  // Clock stands low outside frames; read bits land in password order
  task automatic xfer(input logic [7:0] op, input int nd, input logic [63:0] d, input int nr,
                      input logic m4, output logic [127:0] rd, output logic oe);
    logic s;
    logic e;
    rd = '0;
    oe = 1'h0;
    io4_on = m4;
    cs_n = 1'h0;
    #62.5;
    for (int i = 0; i < 8; i++) put(op[7 - i], s, e);
    for (int i = 0; i < nd; i++) put(d[i / 8 * 8 + 7 - i % 8], s, e);
    for (int i = 0; i < nr; i++) begin
      put(~data_line_zero, s, e);
      rd[i / 64 * 64 + i % 64 / 8 * 8 + 7 - i % 8] = s;
      oe = oe | e;
    end
    #62.5 cs_n = 1'h1;
    // A released line must not keep showing its last bit
    data_line_zero = ~data_line_zero;
    #400;
  endtask
endmodule

// >>> sim/fpl_lock_ctrl_sva.sv
`timescale 1ns/1ps
module fpl_lock_ctrl_chk
  import fpl_pkg::*;
(
  // Clock and reset
  input wire logic  core_clk,
  input wire logic  nrst,
  // Link and array side
  input wire logic  cs_n,
  input wire logic  so,
  input wire logic  so_oe,
  input wire logic  array_busy,
  input wire logic  program_suspend_req,
  input wire logic  erase_suspend_req,
  // Status
  input fpl_status_t status,
  input wire logic  sector_lock,
  input wire logic  freeze,
  input wire logic  program_suspended,
  input wire logic  erase_suspended
);
  logic [1:0] up_ff;

  // Keeps $past and $fell from seeing values from before a reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  cs_idle_a: assert property (cs_n |-> !so_oe)
    else $error("serial output enabled while deselected");
  so_quiet_a: assert property (!so_oe |-> !so)
    else $error("serial output not low while undriven");
  wel_done_a: assert property ($fell(status.write_in_progress) && up_ff == 2'h3 && !array_busy &&
    !$past(array_busy) && !$past(array_busy, 2) |-> !status.write_enable_latch)
    else $error("enable latch kept after operation end");
  lock_clr_a: assert property ($fell(sector_lock) |-> $past(status.write_in_progress))
    else $error("sector lock cleared outside an operation");
  lock_set_a: assert property ($rose(sector_lock) && up_ff == 2'h3 |->
    $past(status.write_in_progress) && !status.perr)
    else $error("sector lock set outside a good unlock");
  err_stuck_a: assert property (status.perr && status.write_in_progress |=> status.write_in_progress || !status.perr)
    else $error("progress bit dropped while error stands");
  err_clear_a: assert property ($fell(status.perr) |-> !status.write_in_progress)
    else $error("error cleared without progress bit");
  psusp_lat_a: assert property (program_suspend_req && array_busy && status.write_in_progress &&
    !program_suspended |-> ##[1:802] !status.write_in_progress)
    else $error("program suspend too slow");
  esusp_lat_a: assert property (erase_suspend_req && array_busy && status.write_in_progress &&
    !erase_suspended |-> ##[1:902] !status.write_in_progress)
    else $error("erase suspend too slow");
  frz_keep_a: assert property (up_ff == 2'h3 |-> !$fell(freeze))
    else $error("freeze cleared without hardware reset");
endmodule

bind fpl_lock_ctrl fpl_lock_ctrl_chk fpl_lock_ctrl_chk_i (.core_clk(core_clk), .nrst(nrst),
  .cs_n(cs_n), .so(so), .so_oe(so_oe), .array_busy(array_busy),
  .program_suspend_req(program_suspend_req), .erase_suspend_req(erase_suspend_req),
  .status(status), .sector_lock(sector_lock), .freeze(freeze),
  .program_suspended(program_suspended), .erase_suspended(erase_suspended));

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  import fpl_pkg::*;
  localparam logic [63:0] PW = 64'h0123456789ABCDEF;
  logic         core_clk = 1'h0;
  logic         nrst, link_sck, cs_n, data_line_zero, data_line_four, so, so_oe, oe;
  logic         pw_mode_n, freeze_set, bp_load, array_busy, pass_prog_fail, resume_req;
  logic         program_suspend_req, erase_suspend_req, cont_read_enter, sector_lock;
  logic         freeze, cont_read, program_suspended, erase_suspended;
  logic [2:0]   bp_load_val;
  logic [127:0] rd;
  fpl_cfg_nv_t  cfg_nv;
  fpl_status_t  status;
  int           miscompares = 0;
  int           check_count = 0;
  int           cyc = 0;

  fpl_lock_ctrl #(.LOCK_CYC(20), .PROG_CYC(20), .UNLK_CYC(20), .RPH_CYC(60)) fpl_lock_ctrl_i (
    .core_clk(core_clk), .nrst(nrst), .link_sck(link_sck), .cs_n(cs_n),
    .data_line_zero(data_line_zero), .data_line_four(data_line_four), .so(so), .so_oe(so_oe),
    .pw_mode_n(pw_mode_n), .cfg_nv(cfg_nv), .freeze_set(freeze_set), .bp_load(bp_load),
    .bp_load_val(bp_load_val), .array_busy(array_busy), .pass_prog_fail(pass_prog_fail),
    .program_suspend_req(program_suspend_req), .erase_suspend_req(erase_suspend_req),
    .resume_req(resume_req), .cont_read_enter(cont_read_enter), .status(status),
    .sector_lock(sector_lock), .freeze(freeze), .cont_read(cont_read),
    .program_suspended(program_suspended), .erase_suspended(erase_suspended));
  fpl_host_model fpl_host_model_i (.link_sck(link_sck), .cs_n(cs_n), .so(so), .so_oe(so_oe),
    .data_line_zero(data_line_zero), .data_line_four(data_line_four));

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fr(input logic [7:0] op, input int nd = 0, input logic [63:0] d = '0,
                    input int nr = 0, input logic m4 = 1'h1);
    fpl_host_model_i.xfer(op, nd, d, nr, m4, rd, oe);
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk) s = 1'h1;
    @(negedge core_clk) s = 1'h0;
  endtask
  task automatic wt(input logic v);
    for (int i = 0; i < 300 && status.write_in_progress !== v; i++) @(negedge core_clk);
    chk(status.write_in_progress, v);
  endtask
  task automatic hrst();
    @(negedge core_clk) nrst = 1'h0;
    repeat (12) @(negedge core_clk);
    nrst = 1'h1;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic lat(ref logic req, input int lim);
    int n = 0;
    pulse(req);
    while (status.write_in_progress !== 1'h0 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n <= lim, 1'h1);
  endtask

  task automatic t_lock();
    chk(sector_lock, 1'h1);
    fr(OPC_LOCK_WR);
    chk(status.write_in_progress, 1'h0);
    fr(OPC_WRITE_ENABLE_CMD);
    fr(OPC_LOCK_WR, 1);
    chk({status.write_in_progress, status.write_enable_latch, sector_lock}, 3'h3);
    fr(OPC_LOCK_WR);
    chk(status.write_in_progress, 1'h1);
    wt(1'h0);
    chk({status.write_enable_latch, sector_lock}, 2'h0);
  endtask
  task automatic t_pass();
    fr(OPC_WRITE_ENABLE_CMD);
    fr(OPC_PASS_PROG, 64, PW);
    chk(status.write_in_progress, 1'h1);
    wt(1'h0);
    chk({status.perr, status.write_enable_latch}, 2'h0);
    fr(OPC_PASS_RD, 0, '0, 128);
    chk({oe, rd[63:0]}, {1'h1, PW});
    chk(rd[127:64], PW);
  endtask
  task automatic t_unlock();
    fr(OPC_PASS_UNLK, 64, ~PW);
    repeat (40) @(negedge core_clk);
    chk({status.perr, status.write_in_progress, sector_lock}, 3'h6);
    fr(OPC_WRITE_ENABLE_CMD);
    chk(status.write_enable_latch, 1'h0);
    fr(OPC_CLR_STAT);
    chk({status.perr, status.write_in_progress}, 2'h0);
    fr(OPC_PASS_UNLK, 63, PW);
    chk({status.write_in_progress, sector_lock}, 2'h0);
    fr(OPC_PASS_UNLK, 64, PW);
    wt(1'h0);
    chk({status.perr, sector_lock}, 2'h1);
  endtask
  task automatic t_reset();
    fr(OPC_WRITE_ENABLE_CMD);
    fr(OPC_LOCK_WR);
    wt(1'h0);
    bp_load_val = 3'h5;
    pulse(bp_load);
    pulse(freeze_set);
    fr(OPC_WRITE_ENABLE_CMD);
    fr(8'hFF);
    fr(OPC_SW_RESET);
    fr(OPC_WRITE_ENABLE_CMD);
    chk({status.write_enable_latch, status.bp, sector_lock, freeze}, 6'h15);
    repeat (80) @(negedge core_clk);
    fr(OPC_WRITE_ENABLE_CMD);
    chk(status.write_enable_latch, 1'h1);
    hrst();
    chk({freeze, sector_lock, status.write_enable_latch}, 3'h2);
    pulse(bp_load);
    fr(OPC_SW_RESET);
    repeat (80) @(negedge core_clk);
    chk({status.bp, sector_lock}, 4'h1);
  endtask
  task automatic t_mbr();
    pulse(cont_read_enter);
    fr(OPC_WRITE_ENABLE_CMD);
    chk(status.write_enable_latch, 1'h0);
    fr(8'hFF, 0, '0, 0, 1'h0);
    chk(cont_read, 1'h1);
    fr(8'hFF);
    fr(OPC_WRITE_ENABLE_CMD);
    chk({cont_read, status.write_enable_latch}, 2'h1);
  endtask
  task automatic t_susp();
    array_busy = 1'h1;
    repeat (4) @(negedge core_clk);
    lat(program_suspend_req, 800);
    chk({program_suspended, erase_suspended}, 2'h2);
    pulse(resume_req);
    repeat (4) @(negedge core_clk);
    lat(erase_suspend_req, 900);
    chk({program_suspended, erase_suspended}, 2'h1);
    pulse(resume_req);
    array_busy = 1'h0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic t_fail();
    pass_prog_fail = 1'h1;
    fr(OPC_WRITE_ENABLE_CMD);
    fr(OPC_PASS_PROG, 64, ~PW);
    repeat (40) @(negedge core_clk);
    chk({status.perr, status.write_in_progress}, 2'h3);
    pass_prog_fail = 1'h0;
    fr(OPC_SW_RESET);
    repeat (80) @(negedge core_clk);
    chk({status.perr, status.write_in_progress}, 2'h0);
  endtask
  task automatic t_pwmode();
    pw_mode_n = 1'h0;
    hrst();
    chk(sector_lock, 1'h0);
    fr(OPC_PASS_RD, 0, '0, 64);
    chk(oe, 1'h0);
    fr(OPC_WRITE_ENABLE_CMD);
    fr(OPC_PASS_PROG, 64, PW);
    chk({status.write_in_progress, status.write_enable_latch}, 2'h1);
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    nrst = 1'h0;
    pw_mode_n = 1'h1;
    cfg_nv = '0;
    {freeze_set, bp_load, bp_load_val, array_busy, pass_prog_fail, resume_req} = '0;
    {program_suspend_req, erase_suspend_req, cont_read_enter} = '0;
    repeat (12) @(negedge core_clk);
    nrst = 1'h1;
    repeat (6) @(negedge core_clk);
    t_lock();
    t_pass();
    t_unlock();
    t_reset();
    t_mbr();
    t_susp();
    t_fail();
    t_pwmode();
    final_report();
  end
endmodule
